// [core/olf_regs.v]
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "olf_defines.vh"

module olf_regs #(
    parameter RESET_CYCLES = `OLF_RESET_CYCLES
)(
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        bulk_head_reached,
    input  wire        ctrl_head_reached,
    input  wire        bulk_td_found,
    input  wire        ctrl_td_found,
    input  wire [6:0]  event_pulse,
    output reg         bulk_list_run,
    output reg         ctrl_list_run,
    output reg         bulk_list_skip,
    output reg         ctrl_list_skip,
    output wire        bus_master_allow,
    output wire        soft_reset_active,
    output wire        force_suspend,
    output wire        irq
);

    // Register state
    reg [31:0] control_reg;
    reg [31:0] cmd_reg;
    reg [31:0] int_flags_reg;
    reg [31:0] int_en_reg;
    reg [15:0] rst_cnt_reg;
    reg        ack_reg;

    wire [31:0] be_mask;
    wire        wr_hit;
    wire        rd_hit;
    wire [31:0] wdata_m;
    wire        rst_done;

    // Byte enable expansion
    function [31:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    assign be_mask  = lane_mask(avs_byteenable);
    assign wdata_m  = avs_writedata & be_mask;
    // Writes land only at the edge where waitrequest is low
    assign wr_hit   = avs_write & ack_reg;
    assign rd_hit   = avs_read & ~ack_reg;

    // One wait cycle per access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ack_reg <= 1'b0;
        else
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    // Soft reset progress
    assign soft_reset_active = cmd_reg[`OLF_CMD_RESET_BIT];
    assign force_suspend     = soft_reset_active;
    assign bus_master_allow  = ~soft_reset_active;
    assign rst_done = soft_reset_active &&
                      (rst_cnt_reg == RESET_CYCLES[15:0] - 16'h0001);

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rst_cnt_reg <= 16'h0000;
        else if (soft_reset_active && !rst_done)
            rst_cnt_reg <= rst_cnt_reg + 16'h0001;
        else
            rst_cnt_reg <= 16'h0000;
    end

    // Control register, routing bit survives soft reset
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            control_reg <= `OLF_CTL_RESET;
        else if (soft_reset_active)
        begin
            control_reg <= `OLF_CTL_RESET;
            control_reg[`OLF_CTL_ROUTE_BIT] <= control_reg[`OLF_CTL_ROUTE_BIT];
        end
        else if (wr_hit && avs_address == `OLF_OFF_CONTROL)
            control_reg <= ((control_reg & ~be_mask) | wdata_m) & `OLF_CTL_MASK;
    end

    // Command/status: write one to set, list flag handling
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cmd_reg <= 32'h00000000;
        else if (soft_reset_active)
        begin
            cmd_reg <= 32'h00000000;
            cmd_reg[`OLF_CMD_RESET_BIT] <= ~rst_done;
        end
        else
        begin
            // Head sampling clears; descriptor or software write sets (set wins)
            if (bulk_head_reached && cmd_reg[`OLF_CMD_BULK_BIT])
                cmd_reg[`OLF_CMD_BULK_BIT] <= 1'b0;
            if (ctrl_head_reached && cmd_reg[`OLF_CMD_CTRL_BIT])
                cmd_reg[`OLF_CMD_CTRL_BIT] <= 1'b0;
            if (bulk_td_found)
                cmd_reg[`OLF_CMD_BULK_BIT] <= 1'b1;
            if (ctrl_td_found)
                cmd_reg[`OLF_CMD_CTRL_BIT] <= 1'b1;
            if (wr_hit && avs_address == `OLF_OFF_CMDSTAT)
            begin
                if (wdata_m[`OLF_CMD_BULK_BIT])
                    cmd_reg[`OLF_CMD_BULK_BIT] <= 1'b1;
                if (wdata_m[`OLF_CMD_CTRL_BIT])
                    cmd_reg[`OLF_CMD_CTRL_BIT] <= 1'b1;
                if (wdata_m[`OLF_CMD_RESET_BIT])
                    cmd_reg[`OLF_CMD_RESET_BIT] <= 1'b1;
                if (wdata_m[`OLF_CMD_OWN_BIT])
                    cmd_reg[`OLF_CMD_OWN_BIT] <= 1'b1;
            end
        end
    end

    // List decisions at the head; an empty pass leaves flag zero
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bulk_list_run  <= 1'b0;
            ctrl_list_run  <= 1'b0;
            bulk_list_skip <= 1'b0;
            ctrl_list_skip <= 1'b0;
        end
        else
        begin
            bulk_list_run  <= bulk_head_reached & cmd_reg[`OLF_CMD_BULK_BIT] &
                              ~soft_reset_active;
            bulk_list_skip <= bulk_head_reached & ~cmd_reg[`OLF_CMD_BULK_BIT];
            ctrl_list_run  <= ctrl_head_reached & cmd_reg[`OLF_CMD_CTRL_BIT] &
                              ~soft_reset_active;
            ctrl_list_skip <= ctrl_head_reached & ~cmd_reg[`OLF_CMD_CTRL_BIT];
        end
    end

    // Interrupt status: hardware sets, software clears by ones, set wins
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            int_flags_reg <= 32'h00000000;
        else if (soft_reset_active)
            int_flags_reg <= 32'h00000000;
        else
        begin
            if (wr_hit && avs_address == `OLF_OFF_INTSTAT)
                int_flags_reg <= (int_flags_reg & ~wdata_m
                                 | {25'h0000000, event_pulse}
                                 | ({31'h0, cmd_reg[`OLF_CMD_OWN_BIT]} << `OLF_INT_OWN_BIT))
                                 & `OLF_INT_MASK;
            else
                int_flags_reg <= (int_flags_reg | {25'h0000000, event_pulse}
                                 | ({31'h0, cmd_reg[`OLF_CMD_OWN_BIT]} << `OLF_INT_OWN_BIT))
                                 & `OLF_INT_MASK;
        end
    end

    // Enable register: write one to set, disable offset clears
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            int_en_reg <= 32'h00000000;
        else if (soft_reset_active)
            int_en_reg <= 32'h00000000;
        else if (wr_hit && avs_address == `OLF_OFF_INTEN)
            int_en_reg <= (int_en_reg | wdata_m) & `OLF_INTEN_MASK;
        else if (wr_hit && avs_address == `OLF_OFF_INTDIS)
            int_en_reg <= int_en_reg & ~wdata_m;
    end

    // Interrupt request
    assign irq = int_en_reg[`OLF_INT_MIE_BIT] &
                 (|(int_flags_reg & int_en_reg & `OLF_INT_MASK));

    // Read data, unmapped reads zero
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= 32'h00000000;
        else if (rd_hit)
        begin
            case (avs_address)
                `OLF_OFF_CONTROL: avs_readdata <= control_reg;
                `OLF_OFF_CMDSTAT: avs_readdata <= cmd_reg & `OLF_CMD_MASK;
                `OLF_OFF_INTSTAT: avs_readdata <= int_flags_reg;
                `OLF_OFF_INTEN:   avs_readdata <= int_en_reg;
                `OLF_OFF_INTDIS:  avs_readdata <= int_en_reg;
                default:          avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // Root hub and port signalling live outside; nothing here drives them

endmodule // olf_regs
`default_nettype wire

// [shared/olf_defines.vh]
`ifndef OLF_DEFINES_VH
`define OLF_DEFINES_VH

// Register byte offsets
`define OLF_OFF_CONTROL      8'h04
`define OLF_OFF_CMDSTAT      8'h08
`define OLF_OFF_INTSTAT      8'h0C
`define OLF_OFF_INTEN        8'h10
`define OLF_OFF_INTDIS       8'h14

// Command/status fields
`define OLF_CMD_RESET_BIT    0
`define OLF_CMD_CTRL_BIT     1
`define OLF_CMD_BULK_BIT     2
`define OLF_CMD_OWN_BIT      3
`define OLF_CMD_MASK         32'h0000000F

// Control register fields
`define OLF_CTL_ROUTE_BIT    8
`define OLF_CTL_MASK         32'h000007FF
`define OLF_CTL_RESET        32'h00000000

// Interrupt fields
`define OLF_INT_OWN_BIT      30
`define OLF_INT_MASK         32'h4000007F
`define OLF_INT_MIE_BIT      31
`define OLF_INTEN_MASK       32'hC000007F

// Reset timing
`define OLF_RESET_LIMIT_NS   10000
`define OLF_CLK_PERIOD_NS    40
`define OLF_RESET_CYCLES     (`OLF_RESET_LIMIT_NS / `OLF_CLK_PERIOD_NS)

`endif

// [testbench/olf_regs_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module olf_regs_bench;
    logic        clk_sys, rst_n, rd_en, wr_en;
    logic [7:0]  addr;
    logic [31:0] wdata, got;
    logic [3:0]  lp;
    logic [6:0]  ev;
    logic [1:0]  rs;
    wire  [31:0] rdata;
    wire         wait_req, br, cr, bs, cs, bma, sra, fsus, irq;
    int          mismatches, samples_checked, cyc, n;
    olf_regs #(.RESET_CYCLES(8)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(addr),
        .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(4'hF),
        .avs_readdata(rdata), .avs_waitrequest(wait_req), .bulk_head_reached(lp[0]),
        .ctrl_head_reached(lp[1]), .bulk_td_found(lp[2]), .ctrl_td_found(lp[3]),
        .event_pulse(ev), .bulk_list_run(br), .ctrl_list_run(cr), .bulk_list_skip(bs),
        .ctrl_list_skip(cs), .bus_master_allow(bma), .soft_reset_active(sra),
        .force_suspend(fsus), .irq(irq));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus access, held until waitrequest low
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        rd_en <= !w;
        wr_en <= w;
        addr <= a;
        wdata <= d;
        do
            @(posedge clk_sys);
        while (wait_req);
        got = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h00000000);
        chk(got, exp);
    endtask
    // One list processor pulse, then its decision
    task automatic pulse(input int w);
        @(posedge clk_sys);
        lp <= 4'h1 << w;
        @(posedge clk_sys);
        lp <= 4'h0;
        #1 rs = w[0] ? {cr, cs} : {br, bs};
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            complete_run();
        end
    end
    // Main sequence
    initial
    begin
        {rst_n, rd_en, wr_en, addr, wdata, lp, ev} = '0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rc(8'h0C, 32'h00000000);
        rc(8'h40, 32'h00000000);
        for (int k = 0; k < 2; k++)
        begin
            pulse(k);
            chk(rs, 32'h00000001);
            acc(1'b1, 8'h08, 32'h00000004 >> k);
            rc(8'h08, 32'h00000004 >> k);
            pulse(k);
            chk(rs, 32'h00000002);
            rc(8'h08, 32'h00000000);
            pulse(k + 2);
            rc(8'h08, 32'h00000004 >> k);
            pulse(k);
            pulse(k);
            chk(rs, 32'h00000001);
            $display("list test %0d done", k);
        end
        @(posedge clk_sys);
        ev <= 7'h7F;
        @(posedge clk_sys);
        ev <= 7'h00;
        rc(8'h0C, 32'h0000007F);
        acc(1'b1, 8'h10, 32'h00000002);
        @(negedge clk_sys);
        chk(irq, 32'h00000000);
        acc(1'b1, 8'h10, 32'h80000000);
        @(negedge clk_sys);
        chk(irq, 32'h00000001);
        acc(1'b1, 8'h0C, 32'h00000007);
        @(negedge clk_sys);
        chk(irq, 32'h00000000);
        repeat (20) @(posedge clk_sys);
        rc(8'h0C, 32'h00000078);
        acc(1'b1, 8'h0C, 32'hFFFFFFFF);
        acc(1'b1, 8'h0C, 32'h0000007F);
        rc(8'h0C, 32'h00000000);
        acc(1'b1, 8'h08, 32'h00000008);
        rc(8'h0C, 32'h40000000);
        $display("status test done");
        acc(1'b1, 8'h04, 32'h00000103);
        acc(1'b1, 8'h08, 32'h00000001);
        @(negedge clk_sys);
        chk(sra & fsus & !bma, 32'h00000001);
        n = 0;
        while (sra !== 1'b0)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(n <= 10, 32'h00000001);
        acc(1'b0, 8'h08, 32'h00000000);
        chk(got & 32'h00000001, 32'h00000000);
        rc(8'h04, 32'h00000100);
        $display("soft reset test done");
        complete_run();
    end
endmodule // olf_regs_bench
bind olf_regs olf_regs_checker #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .bulk_head_reached(bulk_head_reached),
    .ctrl_head_reached(ctrl_head_reached), .bulk_list_run(bulk_list_run),
    .bulk_list_skip(bulk_list_skip), .ctrl_list_run(ctrl_list_run),
    .ctrl_list_skip(ctrl_list_skip), .bus_master_allow(bus_master_allow),
    .soft_reset_active(soft_reset_active), .force_suspend(force_suspend));
`default_nettype wire

// [testbench/olf_regs_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module olf_regs_checker #(
    parameter RESET_CYCLES = 8
)(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic bulk_head_reached,
    input wire logic ctrl_head_reached,
    input wire logic bulk_list_run,
    input wire logic bulk_list_skip,
    input wire logic ctrl_list_run,
    input wire logic ctrl_list_skip,
    input wire logic bus_master_allow,
    input wire logic soft_reset_active,
    input wire logic force_suspend
);
    logic [7:0] rcnt_reg;
    // Length of the current soft reset
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rcnt_reg <= 8'h00;
        else
            rcnt_reg <= soft_reset_active ? rcnt_reg + 8'h01 : 8'h00;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // One wait cycle, then the answer
    sequence s_ans;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    bus_answer_a: assert property ($rose(avs_read || avs_write) |-> s_ans)
        else $error("access not answered after one wait cycle");
    bulk_resp_a: assert property (bulk_head_reached |=> bulk_list_run ^ bulk_list_skip)
        else $error("bulk head gave no single decision");
    ctrl_resp_a: assert property (ctrl_head_reached |=> ctrl_list_run ^ ctrl_list_skip)
        else $error("control head gave no single decision");
    bulk_cause_a: assert property (bulk_list_run || bulk_list_skip |-> $past(bulk_head_reached))
        else $error("bulk decision without head");
    ctrl_cause_a: assert property (ctrl_list_run || ctrl_list_skip |-> $past(ctrl_head_reached))
        else $error("control decision without head");
    no_master_a: assert property (soft_reset_active |-> !bus_master_allow)
        else $error("bus master allowed during soft reset");
    reset_len_a: assert property (rcnt_reg <= RESET_CYCLES + 1)
        else $error("soft reset lasts too long");
    to_suspend_a: assert property ($rose(soft_reset_active) |-> force_suspend)
        else $error("soft reset without suspend");
endmodule // olf_regs_checker
`default_nettype wire
